// >>> hw/wdt_consts.vh
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// time base and clock
`define WDT_REF_CLK_HZ 125000000
`define WDT_TICK_HZ 32768
// unlock keys, written in order before a reload takes effect
`define WDT_KEY1 16'h5a5a
`define WDT_KEY2 16'ha5a5
// reset values
`define WDT_RST_COUNT 16'hffff
`define WDT_RST_PRESC 8'h00
// unlock sequence states
`define WDT_UL_IDLE 2'h0
`define WDT_UL_ONE 2'h1
`define WDT_UL_OPEN 2'h2

`endif

// >>> hw/tick_gen.v
`include "wdt_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// fractional divider: one pulse per 32.768 kHz period
module tick_gen #(
  parameter integer CLK_HZ = `WDT_REF_CLK_HZ,
  parameter integer TICK_HZ = `WDT_TICK_HZ
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // tick out
  output reg o_tick
);

  reg [31:0] acc_reg;
  reg [31:0] acc_next;
  reg tick_next;

  // accumulate tick rate, wrap at clock rate; long-run exact
  always @* begin
    tick_next = 1'b0;
    acc_next = acc_reg + TICK_HZ[31:0];
    if (acc_next >= CLK_HZ[31:0]) begin
      acc_next = acc_next - CLK_HZ[31:0];
      tick_next = 1'b1;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      acc_reg <= 32'h0;
      o_tick <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      o_tick <= tick_next;
    end
  end

endmodule // tick_gen

`default_nettype wire

// >>> hw/watchdog_timer.v
// Functional notes
// - Expiry interrupt repeats at an interval set by the programmed load and prescaler.
// - In watchdog mode, unserviced interrupt for a whole further period raises reset request.
// - Counter decrements on a fixed 32.768 kHz base, not the cpu clock.
// - Selectable modes: free-running timer, or watchdog with reset action.
// - Each end of count of the down counter produces an interrupt event.
`include "wdt_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer #(
  parameter integer CLK_HZ = `WDT_REF_CLK_HZ,
  parameter integer CNT_W = 16,
  parameter integer PRE_W = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // configuration
  input wire i_enable,
  input wire i_wdog_mode,
  input wire [CNT_W-1:0] i_load_value,
  input wire [PRE_W-1:0] i_presc_value,
  // software actions, one-cycle strobes
  input wire i_key_wr,
  input wire [15:0] i_key_data,
  input wire i_irq_clear,
  // status and events
  output reg o_irq,
  output reg reset_request_out,
  output reg [CNT_W-1:0] o_count,
  output reg o_unlocked
);

  // ===================================================================
  // unlock sequence states
  localparam [1:0] UL_IDLE = `WDT_UL_IDLE;
  localparam [1:0] UL_ONE = `WDT_UL_ONE;
  localparam [1:0] UL_OPEN = `WDT_UL_OPEN;

  // ===================================================================
  // time base
  wire tick;

  tick_gen #(
    .CLK_HZ(CLK_HZ),
    .TICK_HZ(`WDT_TICK_HZ)
  ) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .o_tick(tick)
  );

  // ===================================================================
  // key decode
  // keys compared whole; a partial match counts as a wrong key
  wire key_first_hit;
  wire key_second_hit;

  assign key_first_hit = (i_key_data == `WDT_KEY1);
  assign key_second_hit = (i_key_data == `WDT_KEY2);

  // ===================================================================
  // unlock sequence and reload
  // a stray write never reloads: two keys must come first, in order
  reg [1:0] ul_reg;
  reg [1:0] ul_next;
  reg reload;

  always @* begin
    ul_next = ul_reg;
    reload = 1'b0;
    if (i_key_wr) begin
      case (ul_reg)
        UL_IDLE: begin
          if (key_first_hit)
            ul_next = UL_ONE;
        end
        UL_ONE: begin
          if (key_second_hit)
            ul_next = UL_OPEN;
          else
            ul_next = UL_IDLE;
        end
        UL_OPEN: begin
          // any write while open performs the reload and relocks
          reload = 1'b1;
          ul_next = UL_IDLE;
        end
        default: begin
          ul_next = UL_IDLE;
        end
      endcase
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      ul_reg <= UL_IDLE;
    end else begin
      ul_reg <= ul_next;
    end
  end

  // ===================================================================
  // prescaler and down counter
  reg [PRE_W-1:0] pre_reg;
  reg [PRE_W-1:0] pre_next;
  reg [CNT_W-1:0] cnt_next;
  reg expire;
  wire run_tick;
  wire pre_zero;
  wire cnt_zero;

  // counter runs from the fixed tick only, never from i_ref_clk itself
  assign run_tick = i_enable & tick;
  assign pre_zero = (pre_reg == {PRE_W{1'b0}});
  assign cnt_zero = (o_count == {CNT_W{1'b0}});

  // prescaler divides the tick by presc + 1
  always @* begin
    pre_next = pre_reg;
    if (reload) begin
      pre_next = i_presc_value;
    end else if (run_tick) begin
      if (pre_zero) begin
        pre_next = i_presc_value;
      end else begin
        pre_next = pre_reg - 1'b1;
      end
    end
  end

  // one count step per prescaler wrap; expiry at zero reloads
  always @* begin
    cnt_next = o_count;
    expire = 1'b0;
    if (reload) begin
      cnt_next = i_load_value;
    end else if (run_tick && pre_zero) begin
      if (cnt_zero) begin
        expire = 1'b1;
        cnt_next = i_load_value;
      end else begin
        cnt_next = o_count - 1'b1;
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      pre_reg <= `WDT_RST_PRESC;
    end else begin
      pre_reg <= pre_next;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_count <= `WDT_RST_COUNT;
    end else begin
      o_count <= cnt_next;
    end
  end

  // ===================================================================
  // interrupt
  reg irq_next;

  // set wins over a clear in the same cycle
  always @* begin
    irq_next = o_irq;
    if (expire) begin
      irq_next = 1'b1;
    end else if (i_irq_clear) begin
      irq_next = 1'b0;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_next;
    end
  end

  // ===================================================================
  // reset request
  reg rstreq_next;
  wire unserviced;

  // expiry with the last irq still pending: a whole period unserviced
  assign unserviced = expire & o_irq;

  // sticky until i_reset; timer mode never requests a reset
  always @* begin
    rstreq_next = reset_request_out;
    if (unserviced && i_wdog_mode) begin
      rstreq_next = 1'b1;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      reset_request_out <= 1'b0;
    end else begin
      reset_request_out <= rstreq_next;
    end
  end

  // ===================================================================
  // status
  // reload window flag, high while the open state waits for its write
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_unlocked <= 1'b0;
    end else begin
      o_unlocked <= (ul_next == UL_OPEN);
    end
  end

endmodule // watchdog_timer

`default_nettype wire

// >>> tb/wdt_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"
module wdt_sva (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // inputs
  input wire logic i_wdog_mode,
  input wire logic [15:0] i_load_value,
  input wire logic i_key_wr,
  input wire logic [15:0] i_key_data,
  input wire logic i_irq_clear,
  // outputs
  input wire logic o_irq,
  input wire logic reset_request_out,
  input wire logic [15:0] o_count,
  input wire logic o_unlocked
);
  // ==========
  // checks
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_clr; $fell(o_irq) |-> $past(i_irq_clear); endproperty
  a_clr: assert property (p_clr) else $error("irq fell");
  property p_rst;
    $rose(reset_request_out) |-> $past(o_irq) && $past(i_wdog_mode);
  endproperty
  a_rst: assert property (p_rst) else $error("rst req");
  property p_tick;
    $changed(o_count) && !$past(o_unlocked) |=> $stable(o_count);
  endproperty
  a_tick: assert property (p_tick) else $error("count");
  property p_tmr;
    !i_wdog_mode && !reset_request_out |=> !reset_request_out;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer");
  property p_rld; $rose(o_irq) |-> o_count == i_load_value; endproperty
  a_rld: assert property (p_rld) else $error("reload");
  property p_unl;
    $rose(o_unlocked) |-> $past(i_key_wr) && $past(i_key_data) == `WDT_KEY2;
  endproperty
  a_unl: assert property (p_unl) else $error("unlock");
  property p_rel;
    $past(o_unlocked) && $past(i_key_wr) |->
      !o_unlocked && o_count == $past(i_load_value);
  endproperty
  a_rel: assert property (p_rel) else $error("relock");
  c_rst: cover property ($rose(reset_request_out));
  c_unl: cover property ($rose(o_unlocked));
  c_clr: cover property ($fell(o_irq));
endmodule // wdt_sva
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"
module tb_top;
  logic i_ref_clk = 0, i_reset = 1, i_enable = 1, i_wdog_mode = 0;
  logic [15:0] i_load_value = 0, i_key_data = 0, o_count;
  logic [7:0] i_presc_value = 0;
  logic i_key_wr = 0, i_irq_clear = 0, o_irq, reset_request_out, o_unlocked;
  int miscompares = 0, tests_run = 0, seed = 32'h4f20, n, p;
  // ==========
  // clock, design and helpers
  always #4 i_ref_clk = ~i_ref_clk;
  watchdog_timer #(.CLK_HZ(65536)) u_watchdog_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_enable(i_enable),
    .i_wdog_mode(i_wdog_mode),
    .i_load_value(i_load_value),
    .i_presc_value(i_presc_value),
    .i_key_wr(i_key_wr),
    .i_key_data(i_key_data),
    .i_irq_clear(i_irq_clear),
    .o_irq(o_irq),
    .reset_request_out(reset_request_out),
    .o_count(o_count),
    .o_unlocked(o_unlocked)
  );
  function automatic int per(int l, int q);
    return (l + 1) * (q + 1) * 2;
  endfunction
  task automatic complete_run;
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic step(int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic key(logic [15:0] d);
    step(1);
    i_key_wr = 1;
    i_key_data = d;
    step(1);
    i_key_wr = 0;
  endtask
  task automatic wirq(output int c);
    c = 0;
    while (o_irq !== 1'b1) begin
      step(1);
      c++;
      if (c > 5000) begin
        miscompares++;
        complete_run;
      end
    end
  endtask
  initial begin
    for (int k = 0; k < 3; k++) begin
      i_reset = 1;
      i_wdog_mode = 0;
      step(8);
      i_reset = 0;
      chk("count", 16'hffff, o_count);
      chk("irq", 0, o_irq);
      chk("rstreq", 0, reset_request_out);
      key(`WDT_KEY1);
      key(16'h1234);
      key(16'h0000);
      chk("unlk", 0, o_unlocked);
      i_load_value = k ? 16'(2 + {$random(seed)} % 8) : 16'h0001;
      i_presc_value = k ? 8'({$random(seed)} % 4) : 8'h00;
      p = per(i_load_value, i_presc_value);
      key(`WDT_KEY1);
      key(`WDT_KEY2);
      chk("unlk", 1, o_unlocked);
      key(16'h0000);
      chk("load", i_load_value, o_count);
      wirq(n);
      i_irq_clear = 1;
      step(1);
      i_irq_clear = 0;
      chk("irq", 0, o_irq);
      wirq(n);
      chk("period", 16'(p), 16'(n + 1));
      step(2 * p);
      chk("rstreq", 0, reset_request_out);
      i_wdog_mode = 1;
      step(2 * p);
      chk("rstreq", 1, reset_request_out);
      i_enable = 0;
      n = o_count;
      step(3 * p);
      chk("hold", 16'(n), o_count);
      i_enable = 1;
    end
    complete_run;
  end
endmodule // tb_top
bind watchdog_timer wdt_sva u_wdt_sva (
  .i_ref_clk(i_ref_clk),
  .i_reset(i_reset),
  .i_wdog_mode(i_wdog_mode),
  .i_load_value(i_load_value),
  .i_key_wr(i_key_wr),
  .i_key_data(i_key_data),
  .i_irq_clear(i_irq_clear),
  .o_irq(o_irq),
  .reset_request_out(reset_request_out),
  .o_count(o_count),
  .o_unlocked(o_unlocked)
);
`default_nettype wire
